// >>> hw/elr_regs.sv
`timescale 1ns/1ps
// Contract
// [R1] sticky read-only five-bit first-error pointer in bits 4:0, reset zero
// [R2] bit 5 always reads one: end-to-end crc generation capable
// [R3] sticky writable bit 6 enables crc generation, resets zero
// [R4] bit 7 always reads one: end-to-end crc check capable
// [R5] sticky writable bit 8 enables crc checking; bits 31:9 reserved
// [R6] sticky 128-bit header log, first dword lowest, bytes big-endian
// [R7] capability header reads id 0002h and version 1h
// [R8] capability header next pointer in bits 31:20 resets to 20Ch
// [R9] extra channel count: upper bits zero, low bit from strap, loadable; a configuration load writes all three bits, so upper bits can be nonzero
// [R10] low-priority group count in bits 6:4, resets 000b, loadable
// [R11] reference clock field bits 9:8 reads 00b for 100 ns
// [R12] entry size field bits 11:10 reads 10b for 4-bit entries
// [R13] arbitration capability byte 03h with extra channel count bit 0 one, else 00h
// [R14] table offset bits 31:24 in 16-byte units, 03h with extra channel
// [R15] writing one to control bit 0 applies table; reads as zero
// [R16] scheme field bits 3:1 accepts 0 and 1, others mean default
// [R17] status bit 16 set on table write, cleared when load finishes
// [R18] sticky fields clear only on cold reset
// [R19] reserved bits read zero and ignore writes
// [R20] log captured only for unmasked error with none pending
module elr_regs (
  // clock and resets
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  cold_rst_n,
  // strap pin
  input  wire logic                  extended_channel_strap,
  // register port
  input  wire logic [11:0]           addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [31:0]           rdata,
  // error and configuration memory events
  input  wire elr_pkg::elr_err_evt_t err_evt,
  input  wire elr_pkg::elr_cfg_load_t cfg_load,
  // arbiter side
  input  wire logic                  table_load_done,
  output logic                       crc_gen_en,
  output logic                       crc_chk_en,
  output logic      [2:0]            channel_arb_scheme,
  output logic                       apply_channel_arb_table
);

  logic        rst_meta_r;
  logic        rst_sync_r;
  logic        cold_meta_r;
  logic        cold_sync_r;
  logic        strap_meta_r;
  logic        strap_sync_r;
  logic        strap_taken_r;
  logic [4:0]  first_err_r;
  logic [127:0] hdr_log_r;
  logic        gen_en_r;
  logic        chk_en_r;
  logic [2:0]  extra_channel_count_r;
  logic [2:0]  low_priority_channel_group_r;
  logic [2:0]  scheme_r;
  logic        apply_r;
  logic        dirty_r;
  logic [31:0] rdata_nxt;
  logic [31:0] rdata_r;

  // 16-byte word offset from capability base
  function automatic logic [7:0] tbl_off(input logic ext);
    tbl_off = ext ? elr_pkg::TBL_OFF_ON : elr_pkg::TBL_OFF_OFF;
  endfunction : tbl_off

  // reset release synchronisers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  always_ff @(posedge clock or negedge cold_rst_n)
  begin
    if (!cold_rst_n)
    begin
      cold_meta_r <= 1'b0;
      cold_sync_r <= 1'b0;
    end
    else
    begin
      cold_meta_r <= 1'b1;
      cold_sync_r <= cold_meta_r;
    end
  end

  // strap pin synchroniser, free running so the level is settled at reset release
  always_ff @(posedge clock)
  begin
    strap_meta_r <= extended_channel_strap;
    strap_sync_r <= strap_meta_r; // see [R9]
  end

  // strap capture after release, then configuration memory override
  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      strap_taken_r                <= 1'b0;
      extra_channel_count_r        <= 3'h0;
      low_priority_channel_group_r <= elr_pkg::LPG_RST; // see [R10]
    end
    else if (cfg_load.valid)
    begin
      strap_taken_r                <= 1'b1;
      extra_channel_count_r        <= cfg_load.extra_count; // see [R9]
      low_priority_channel_group_r <= cfg_load.low_group;   // see [R10]
    end
    else if (!strap_taken_r)
    begin
      strap_taken_r         <= 1'b1;
      extra_channel_count_r <= {2'b00, strap_sync_r}; // see [R9]
    end
  end

  // sticky error log, cleared by cold reset only
  always_ff @(posedge clock or negedge cold_sync_r)
  begin
    if (!cold_sync_r)
    begin
      first_err_r <= 5'h00; // see [R18]
      hdr_log_r   <= '0;
    end
    else if (err_evt.valid && err_evt.unmasked && !err_evt.pending) // see [R20]
    begin
      first_err_r <= err_evt.bit_index; // see [R1]
      hdr_log_r   <= err_evt.header;    // see [R6]
    end
  end

  // sticky crc enables
  always_ff @(posedge clock or negedge cold_sync_r)
  begin
    if (!cold_sync_r)
    begin
      gen_en_r <= 1'b0;
      chk_en_r <= 1'b0;
    end
    else if (wr && addr == elr_pkg::OFF_ERR_CTRL)
    begin
      gen_en_r <= wdata[elr_pkg::GEN_EN_BIT]; // see [R3]
      chk_en_r <= wdata[elr_pkg::CHK_EN_BIT]; // see [R5]
    end
  end

  // scheme select and load pulse
  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      scheme_r <= elr_pkg::SCHEME_RST;
      apply_r  <= 1'b0;
    end
    else
    begin
      apply_r <= wr && addr == elr_pkg::OFF_PCH_CTRL && wdata[elr_pkg::LOAD_BIT]; // see [R15]
      if (wr && addr == elr_pkg::OFF_PCH_CTRL)
      begin
        if (wdata[3:1] <= elr_pkg::SCHEME_MAX)
          scheme_r <= wdata[3:1];
        else
          scheme_r <= elr_pkg::SCHEME_RST; // see [R16]
      end
    end
  end

  // table dirty flag, set beats clear
  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      dirty_r <= 1'b0;
    else if (wr && addr == elr_pkg::OFF_ARB_TABLE)
      dirty_r <= 1'b1; // see [R17]
    else if (table_load_done)
      dirty_r <= 1'b0; // see [R17]
  end

  // read decode
  always_comb
  begin
    rdata_nxt = 32'h0000_0000; // see [R19]
    if (addr == elr_pkg::OFF_ERR_CTRL)
    begin
      rdata_nxt[4:0]                     = first_err_r; // see [R1]
      rdata_nxt[elr_pkg::GEN_CAP_BIT]    = 1'b1;        // see [R2]
      rdata_nxt[elr_pkg::GEN_EN_BIT]     = gen_en_r;
      rdata_nxt[elr_pkg::CHK_CAP_BIT]    = 1'b1;        // see [R4]
      rdata_nxt[elr_pkg::CHK_EN_BIT]     = chk_en_r;
    end
    else if (addr == elr_pkg::OFF_HDR_LOG0)
      rdata_nxt = hdr_log_r[31:0];
    else if (addr == elr_pkg::OFF_HDR_LOG1)
      rdata_nxt = hdr_log_r[63:32];
    else if (addr == elr_pkg::OFF_HDR_LOG2)
      rdata_nxt = hdr_log_r[95:64];
    else if (addr == elr_pkg::OFF_HDR_LOG3)
      rdata_nxt = hdr_log_r[127:96];
    else if (addr == elr_pkg::OFF_CH_HDR)
      rdata_nxt = {elr_pkg::NEXT_PTR_RST, elr_pkg::CAP_VER, elr_pkg::CAP_ID}; // see [R7] see [R8]
    else if (addr == elr_pkg::OFF_PCH_CAP1)
    begin
      rdata_nxt[2:0]   = extra_channel_count_r;
      rdata_nxt[6:4]   = low_priority_channel_group_r;
      rdata_nxt[9:8]   = elr_pkg::REF_CLK_100NS; // see [R11]
      rdata_nxt[11:10] = elr_pkg::ENTRY_4BIT;    // see [R12]
    end
    else if (addr == elr_pkg::OFF_PCH_CAP2)
    begin
      rdata_nxt[7:0]   = extra_channel_count_r[0] ? elr_pkg::ARB_CAP_ON : elr_pkg::ARB_CAP_OFF; // see [R13]
      rdata_nxt[31:24] = tbl_off(extra_channel_count_r[0]); // see [R14]
    end
    else if (addr == elr_pkg::OFF_PCH_CTRL)
    begin
      rdata_nxt[3:1]                   = scheme_r; // load bit reads zero, see [R15]
      rdata_nxt[elr_pkg::DIRTY_BIT]    = dirty_r;
    end
  end

  // read data register, one cycle after strobe
  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      rdata_r <= 32'h0000_0000;
    else if (rd)
      rdata_r <= rdata_nxt;
    else
      rdata_r <= 32'h0000_0000;
  end

  assign rdata                   = rdata_r;
  assign crc_gen_en              = gen_en_r;
  assign crc_chk_en              = chk_en_r;
  assign channel_arb_scheme      = scheme_r;
  assign apply_channel_arb_table = apply_r;

endmodule : elr_regs

// >>> hw/elr_pkg.sv
package elr_pkg;

  // register byte offsets
  localparam logic [11:0] OFF_ERR_CTRL  = 12'h118;
  localparam logic [11:0] OFF_HDR_LOG0  = 12'h11C;
  localparam logic [11:0] OFF_HDR_LOG1  = 12'h120;
  localparam logic [11:0] OFF_HDR_LOG2  = 12'h124;
  localparam logic [11:0] OFF_HDR_LOG3  = 12'h128;
  localparam logic [11:0] OFF_CH_HDR    = 12'h140;
  localparam logic [11:0] OFF_PCH_CAP1  = 12'h144;
  localparam logic [11:0] OFF_PCH_CAP2  = 12'h148;
  localparam logic [11:0] OFF_PCH_CTRL  = 12'h14C;
  // table entry window offset, chosen locally
  localparam logic [11:0] OFF_ARB_TABLE = 12'h170;

  // error control field positions
  localparam int FEP_LSB      = 0;
  localparam int GEN_CAP_BIT  = 5;
  localparam int GEN_EN_BIT   = 6;
  localparam int CHK_CAP_BIT  = 7;
  localparam int CHK_EN_BIT   = 8;

  // capability header values
  localparam logic [15:0] CAP_ID       = 16'h0002;
  localparam logic [3:0]  CAP_VER      = 4'h1;
  localparam logic [11:0] NEXT_PTR_RST = 12'h20C;

  // port capability values
  localparam logic [1:0]  REF_CLK_100NS = 2'h0;
  localparam logic [1:0]  ENTRY_4BIT    = 2'h2;
  localparam logic [7:0]  ARB_CAP_ON    = 8'h03;
  localparam logic [7:0]  ARB_CAP_OFF   = 8'h00;
  localparam logic [7:0]  TBL_OFF_ON    = 8'h03;
  localparam logic [7:0]  TBL_OFF_OFF   = 8'h00;
  localparam logic [2:0]  LPG_RST       = 3'h0;

  // control and status
  localparam int          LOAD_BIT      = 0;
  localparam int          DIRTY_BIT     = 16;
  localparam logic [2:0]  SCHEME_RST    = 3'h0;
  localparam logic [2:0]  SCHEME_MAX    = 3'h1;

  // error event carrier
  typedef struct packed {
    logic         valid;
    logic [4:0]   bit_index;
    logic         unmasked;
    logic         pending;
    logic [127:0] header;
  } elr_err_evt_t;

  // configuration memory override carrier
  typedef struct packed {
    logic       valid;
    logic [2:0] extra_count;
    logic [2:0] low_group;
  } elr_cfg_load_t;

endpackage : elr_pkg

// >>> bench/elr_regs_assertions.sv
`timescale 1ns/1ps
module elr_chk (
  // clock, resets, strap
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        cold_rst_n,
  input wire logic        extended_channel_strap,
  // register port
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // events and arbiter side
  input wire elr_pkg::elr_err_evt_t  err_evt,
  input wire elr_pkg::elr_cfg_load_t cfg_load,
  input wire logic        table_load_done,
  input wire logic        crc_gen_en,
  input wire logic        crc_chk_en,
  input wire logic [2:0]  channel_arb_scheme,
  input wire logic        apply_channel_arb_table
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n || !cold_rst_n);
  // decoded accesses and legal scheme value
  wire       w_ctl = wr && addr == 12'h14C;
  wire       w_err = wr && addr == 12'h118;
  wire [2:0] sch   = wdata[3:1] > 3'h1 ? 3'h0 : wdata[3:1];
  chk_apply_pulse: assert property (w_ctl && wdata[0] |=> apply_channel_arb_table)
    else $error("no apply pulse");
  chk_apply_cause: assert property (apply_channel_arb_table |-> $past(w_ctl && wdata[0]))
    else $error("stray apply pulse");
  chk_scheme_set: assert property (w_ctl |=> channel_arb_scheme == $past(sch))
    else $error("bad scheme");
  chk_scheme_hold: assert property (!w_ctl |=> $stable(channel_arb_scheme))
    else $error("scheme moved");
  chk_ctrl_read: assert property (rd && addr == 12'h14C |=> rdata[15:0] == {12'h0, channel_arb_scheme, 1'b0})
    else $error("bad control read");
  chk_err_read: assert property (rd && addr == 12'h118 |=> rdata[31:5] == {23'h0, crc_chk_en, 1'b1, crc_gen_en, 1'b1})
    else $error("bad error control read");
  chk_crc_write: assert property (w_err |=> {crc_chk_en, crc_gen_en} == {$past(wdata[8]), $past(wdata[6])})
    else $error("crc enable not written");
  chk_hdr_read: assert property (rd && addr == 12'h140 |=> rdata == {elr_pkg::NEXT_PTR_RST, 4'h1, 16'h0002})
    else $error("bad capability header");
  // main scenarios reached
  cov_apply: cover property (apply_channel_arb_table);
  cov_done: cover property (table_load_done);
  cov_err: cover property (err_evt.valid && err_evt.unmasked);
endmodule : elr_chk
bind elr_regs elr_chk u_elr_chk (.*);

// >>> bench/error_log_and_vc_arbitration_regs_tb_top.sv
`timescale 1ns/1ps
module error_log_and_vc_arbitration_regs_tb_top;
  // design ports and bench state
  logic clock = 1'b0, rst_n = 1'b0, cold_rst_n = 1'b0, extended_channel_strap = 1'b1;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, lfsr_r = 32'h6905;
  logic wr = 1'b0, rd = 1'b0, table_load_done = 1'b0;
  logic crc_gen_en, crc_chk_en, apply_channel_arb_table;
  logic [2:0] channel_arb_scheme;
  elr_pkg::elr_err_evt_t err_evt = '0;
  elr_pkg::elr_cfg_load_t cfg_load = '0;
  logic [127:0] hdr;
  int error_cnt = 0, checked = 0;
  elr_regs u_elr_regs (.*);
  // 10 MHz clock
  always #50 clock = ~clock;
  // random source and expected control word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] ctl_exp(input logic [2:0] v);
    return {28'h0, v > 3'h1 ? 3'h0 : v, 1'b0};
  endfunction : ctl_exp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_t(input logic [11:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_t
  task automatic rd_t(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_t
  task automatic reset_t(input logic cold);
    @(posedge clock);
    rst_n <= 1'b0;
    cold_rst_n <= ~cold;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    cold_rst_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask : reset_t
  task automatic err_t(input logic [4:0] i, input logic u, input logic p, input logic [127:0] h);
    @(posedge clock);
    err_evt <= '{1'b1, i, u, p, h};
    @(posedge clock);
    err_evt <= '0;
  endtask : err_t
  task automatic log_t(input logic [4:0] i, input logic [127:0] h);
    rd_t(12'h118, {23'h0, 9'h1E0 | i});
    for (int k = 0; k < 4; k++)
      rd_t(12'h11C + 12'(4 * k), h[32 * k +: 32]);
  endtask : log_t
  task automatic end_of_test;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  // hang guard
  initial
  begin
    #5000000 error_cnt++;
    end_of_test();
  end
  // main sequence
  initial
  begin
    reset_t(1'b1);
    rd_t(12'h118, 32'hA0);
    rd_t(12'h140, 32'h20C1_0002);
    rd_t(12'h144, 32'h801);
    rd_t(12'h148, 32'h0300_0003);
    rd_t(12'h14C, 32'h0); // after reset
    wr_t(12'h200, 32'hFFFF_FFFF);
    rd_t(12'h200, 32'h0);
    $display("test done: reset values");
    repeat (8)
    begin
      lfsr_r = lfsr(lfsr_r);
      wr_t(12'h140, lfsr_r);
      wr_t(12'h118, lfsr_r);
      rd_t(12'h118, 32'hA0 | (lfsr_r & 32'h140));
      chk({31'h0, crc_chk_en}, {31'h0, lfsr_r[8]});
      rd_t(12'h140, 32'h20C1_0002);
    end
    $display("test done: crc enables");
    for (int v = 0; v < 8; v++)
    begin
      lfsr_r = lfsr(lfsr_r);
      wr_t(12'h14C, {lfsr_r[31:4], 3'(v), 1'b1});
      #1 chk({31'h0, apply_channel_arb_table}, 32'h1);
      rd_t(12'h14C, ctl_exp(3'(v)));
    end
    wr_t(12'h170, lfsr_r);
    rd_t(12'h14C, 32'h1_0000);
    @(posedge clock);
    table_load_done <= 1'b1;
    @(posedge clock);
    table_load_done <= 1'b0;
    rd_t(12'h14C, 32'h0); // cleared
    $display("test done: arbitration control");
    hdr = {lfsr(lfsr_r), lfsr(~lfsr_r), ~lfsr_r, lfsr_r};
    wr_t(12'h118, 32'h140);
    err_t(5'h13, 1'b1, 1'b0, hdr);
    err_t(5'h04, 1'b1, 1'b1, ~hdr);
    err_t(5'h07, 1'b0, 1'b0, ~hdr);
    log_t(5'h13, hdr);
    reset_t(1'b0);
    log_t(5'h13, hdr);
    $display("test done: error log");
    @(posedge clock);
    cfg_load <= '{1'b1, 3'h6, 3'h2};
    @(posedge clock);
    cfg_load <= '0;
    rd_t(12'h144, 32'h826);
    rd_t(12'h148, 32'h0);
    extended_channel_strap <= 1'b0;
    reset_t(1'b1);
    rd_t(12'h118, 32'hA0);
    rd_t(12'h144, 32'h800);
    $display("test done: load and cold reset");
    end_of_test();
  end
endmodule : error_log_and_vc_arbitration_regs_tb_top
